// *** common/clkgrp_regs.svh ***
// Register indices, field positions, reset values and divide and delay constants of the clock output group block.
`ifndef CLKGRP_REGS_SVH
`define CLKGRP_REGS_SVH
`define IDX_GROUP0        5'h00
`define IDX_FMT0          5'h06
`define IDX_REFOUT        5'h0A
`define IDX_SYNC_CTRL     5'h0B
`define IDX_FB_DIV        5'h1E
`define DIV_LSB           5
`define DIV_MSB           15
`define HS_BIT            16
`define ADLY_SEL_X_BIT    28
`define ADLY_SEL_Y_BIT    29
`define GRP_PD_BIT        31
`define FMT_LSB           16
`define ADLY_LO_LSB       5
`define ADLY_HI_LSB       11
`define REF_B_AMP_LSB     30
`define REF_A_FMT_LSB     24
`define REF_B_EN_BIT      23
`define REF_A_EN_BIT      22
`define EXCL_LSB          5
`define GROUP_RST         32'h0000_0020
`define FMT_RST           32'h0000_0000
`define REFOUT_RST        32'h0000_0000
`define SYNC_CTRL_RST     32'h0000_0000
`define EXT_MODE_DIV      11'h01A
`define ADLY_FIXED_PS     11'h1F4
`define ADLY_STEP_PS      11'h019
`define ADLY_MAX_CODE     5'h17
`endif

// *** common/clkgrp_pkg.sv ***
// Types shared by the clock output group block.
package clkgrp_pkg;
    typedef logic [10:0] divide_t;
    typedef enum logic [3:0] {
        FMT_POWER_DOWN = 4'h0, FMT_LVDS     = 4'h1, FMT_PECL_700  = 4'h2, FMT_PECL_1200 = 4'h3,
        FMT_PECL_1600  = 4'h4, FMT_PECL_2000 = 4'h5, FMT_CMOS_NI  = 4'h6, FMT_CMOS_IN   = 4'h7,
        FMT_CMOS_NN    = 4'h8, FMT_CMOS_II  = 4'h9, FMT_CMOS_LN   = 4'hA, FMT_CMOS_LI   = 4'hB,
        FMT_CMOS_NL    = 4'hC, FMT_CMOS_IL  = 4'hD, FMT_CMOS_LL   = 4'hE, FMT_UNUSED    = 4'hF
    } output_format_t;
endpackage

// *** common/group_div_if.sv ***
// Connection between the configuration top and one group divider.
`timescale 1ns/1ps
`default_nettype none
interface group_div_if;
    import clkgrp_pkg::*;
    divide_t shadow_div;
    logic    sync_pulse;
    logic    excluded;
    logic    clk_out;
    logic    extended;
    modport ctrl (output shadow_div, output sync_pulse, output excluded, input clk_out, input extended);
    modport div  (input shadow_div, input sync_pulse, input excluded, output clk_out, output extended);
endinterface
`default_nettype wire

// *** design/group_divider.sv ***
// Fifty percent duty group divider with divide values from 1 to 2047.
`timescale 1ns/1ps
`default_nettype none
`include "clkgrp_regs.svh"
module group_divider
    import clkgrp_pkg::*;
(
    input  wire logic    ref_clk,
    input  wire logic    rstn,
    group_div_if.div     dv
);
    divide_t    active_r;
    divide_t    cnt_r;
    divide_t    cnt_nxt;
    logic [11:0] len_sum;
    divide_t    high_len;
    logic       q_p_r;
    logic       q_n_r;
    logic       take_sync;

    // A sync that the group is not excluded from reloads a nonzero divide and restarts the count.
    assign take_sync = dv.sync_pulse && !dv.excluded; // [R15]
    assign len_sum   = {1'b0, active_r} + 12'h001;
    assign high_len  = len_sum[11:1];

    always_comb begin
        cnt_nxt = cnt_r + 11'h001;
        if (take_sync || cnt_r >= active_r - 11'h001) begin
            cnt_nxt = 11'h000;
        end
    end

    // New divide values wait for a sync so that both outputs of the group restart in phase.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            active_r <= 11'h001;
        end else if (take_sync && dv.shadow_div != 11'h000) begin
            active_r <= dv.shadow_div; // [R17] [R1]
        end
    end

    // Count position within one output period.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 11'h000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // The high phase lasts half the period rounded up on the rising edge.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q_p_r <= 1'b0;
        end else begin
            q_p_r <= (cnt_nxt < high_len); // [R2]
        end
    end

    // A falling-edge copy trims odd ratios by half a cycle, which is what keeps them at fifty percent.
    always_ff @(negedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q_n_r <= 1'b0;
        end else begin
            q_n_r <= q_p_r;
        end
    end

    // Divide by one bypasses the counter entirely.
    assign dv.clk_out  = (active_r == 11'h001) ? ref_clk :
                         (active_r[0] ? (q_p_r & q_n_r) : q_p_r); // [R16] [R2]
    assign dv.extended = (active_r >= `EXT_MODE_DIV); // [R3]

    // A sync in either of the two cycles after a rise restarts the count, so the even check waits for two quiet ones.
    sequence div4_rise_s;
        $rose(q_p_r) && active_r == 11'h004 && !take_sync ##1 !take_sync;
    endsequence

    chk_active_nonzero: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
        active_r != 11'h000) else $error("active divide became zero");
    chk_sync_restart: assert property (@(posedge ref_clk) disable iff (!rstn) // [R17]
        take_sync |=> cnt_r == 11'h000) else $error("sync did not restart the count");
    chk_excluded_runs: assert property (@(posedge ref_clk) disable iff (!rstn) // [R15]
        (dv.sync_pulse && dv.excluded) |=> $stable(active_r)) else $error("excluded group reloaded");
    chk_even_high_len: assert property (@(posedge ref_clk) disable iff (!rstn) // [R2]
        div4_rise_s |-> q_p_r ##1 !q_p_r) else $error("divide by four high phase wrong");
endmodule // group_divider
`default_nettype wire

// *** design/clock_output_group_config.sv ***
// Register file, serial write port and output decode for twelve clock outputs and two reference outputs.
`timescale 1ns/1ps
`default_nettype none
`include "clkgrp_regs.svh"
// Overview of operation
// R1: Eleven-bit divide at 15:5, zero reserved.
// R2: Even and odd divides give fifty percent duty.
// R3: Divide of 26 or more means extended mode.
// R4: Host keeps half step clear at divide one.
// R5: Feedback divide write issues automatic sync.
// R6: Four-bit format per output in nibbles.
// R7: Format codes pick off, LVDS, LVPECL, LVCMOS.
// R8: Five-bit delay code at 9:5 or 15:11.
// R9: Delay is 500 ps plus 25 ps steps.
// R10: Delay needs select; unselected block powers down.
// R11: Reference output B is LVPECL, amplitude code.
// R12: Reference output A has four-bit format field.
// R13: Output A drives when format on and enabled.
// R14: Half step bit subtracts half period delay.
// R15: Excluded group keeps running through sync.
// R16: Divide of one passes clock straight through.
// R17: New divide takes effect at next sync.
module clock_output_group_config
    import clkgrp_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    input  wire logic          ser_clk,
    input  wire logic          ser_data,
    input  wire logic          ser_latch,
    input  wire logic          sync_req,
    output logic [11:0]        clock_output_p,
    output logic [11:0]        clock_output_n,
    output logic [11:0]        output_lvds,
    output logic [11:0]        output_lvpecl,
    output logic [11:0]        output_lvcmos,
    output logic [5:0]         group_extended,
    output logic [5:0]         group_half_step,
    output logic [11:0]        analog_delay_on,
    output logic [5:0]         delay_block_power,
    output logic [65:0]        analog_delay_ps,
    output logic [3:0]         ref_a_format,
    output logic               ref_a_drive,
    output logic               ref_b_drive,
    output logic [10:0]        ref_b_amp_mv,
    output logic               sync_issued
);
    logic [31:0] shift_r;
    logic        ser_clk_r;
    logic        ser_latch_r;
    logic        latch_pulse;
    logic [4:0]  wr_idx;
    logic [31:0] group_r [6];
    logic [31:0] fmt_r [3];
    logic [31:0] refout_r;
    logic [31:0] sync_ctrl_r;
    logic        sync_r;
    logic [11:0] out_clk;
    logic [5:0]  grp_clk;

    // Serial frames are 32 bits, most significant first, with the register index in the low five bits.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ser_clk_r   <= 1'b0;
            ser_latch_r <= 1'b0;
        end else begin
            ser_clk_r   <= ser_clk;
            ser_latch_r <= ser_latch;
        end
    end

    // Shift on each rising edge of the serial clock.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shift_r <= 32'h0000_0000;
        end else if (ser_clk && !ser_clk_r) begin
            shift_r <= {shift_r[30:0], ser_data};
        end
    end

    assign latch_pulse = ser_latch && !ser_latch_r;
    assign wr_idx      = shift_r[4:0];

    // Clock group registers; the index bits are stored too but steer nothing.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int g = 0; g < 6; g++) begin
                group_r[g] <= `GROUP_RST;
            end
        end else if (latch_pulse && wr_idx < `IDX_FMT0) begin
            group_r[wr_idx[2:0]] <= shift_r; // [R1]
        end
    end

    // Format and analog delay registers.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int f = 0; f < 3; f++) begin
                fmt_r[f] <= `FMT_RST;
            end
        end else if (latch_pulse && wr_idx >= `IDX_FMT0 && wr_idx < `IDX_FMT0 + 5'h03) begin
            fmt_r[2'(wr_idx - `IDX_FMT0)] <= shift_r; // [R6] [R8]
        end
    end

    // Reference output and sync exclusion registers.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            refout_r    <= `REFOUT_RST;
            sync_ctrl_r <= `SYNC_CTRL_RST;
        end else if (latch_pulse) begin
            if (wr_idx == `IDX_REFOUT) begin
                refout_r <= shift_r;
            end
            if (wr_idx == `IDX_SYNC_CTRL) begin
                sync_ctrl_r <= shift_r;
            end
        end
    end

    // A write of the synthesiser feedback divide raises one sync, as does the external request.
    // Groups at divide 2, 4 or 5 rely on this and must not be excluded by the host.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync_r <= 1'b0;
        end else begin
            sync_r <= (latch_pulse && wr_idx == `IDX_FB_DIV) || sync_req; // [R5]
        end
    end
    assign sync_issued = sync_r;

    // One divider per pair of outputs.
    for (genvar g = 0; g < 6; g++) begin : grp
        group_div_if gi ();
        assign gi.shadow_div = group_r[g][`DIV_MSB:`DIV_LSB]; // [R1]
        assign gi.sync_pulse = sync_r;
        assign gi.excluded   = sync_ctrl_r[`EXCL_LSB + g]; // [R15]
        assign grp_clk[g]    = gi.clk_out & !group_r[g][`GRP_PD_BIT];
        group_divider u_div (
            .ref_clk (ref_clk),
            .rstn    (rstn),
            .dv      (gi.div)
        );

        // Delay code of this group, clamped to the top step so a reserved code cannot overrun the delay line.
        logic [4:0] adly_raw;
        logic [4:0] adly_code;
        assign adly_raw  = (g % 2 != 0) ? fmt_r[g/2][`ADLY_HI_LSB+4:`ADLY_HI_LSB]
                                        : fmt_r[g/2][`ADLY_LO_LSB+4:`ADLY_LO_LSB]; // [R8]
        assign adly_code = (adly_raw > `ADLY_MAX_CODE) ? `ADLY_MAX_CODE : adly_raw; // [R9]

        // Group status and analog delay set-up.
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                group_extended[g]           <= 1'b0;
                group_half_step[g]          <= 1'b0;
                analog_delay_on[2*g+1:2*g]  <= 2'b00;
                delay_block_power[g]        <= 1'b0;
                analog_delay_ps[11*g+10:11*g] <= 11'h000;
            end else begin
                group_extended[g]          <= gi.extended; // [R3]
                // The half step itself is applied by the digital delay stage downstream.
                group_half_step[g]         <= group_r[g][`HS_BIT]; // [R14]
                analog_delay_on[2*g]       <= group_r[g][`ADLY_SEL_X_BIT]; // [R10]
                analog_delay_on[2*g+1]     <= group_r[g][`ADLY_SEL_Y_BIT]; // [R10]
                delay_block_power[g]       <= group_r[g][`ADLY_SEL_X_BIT] | group_r[g][`ADLY_SEL_Y_BIT]; // [R10]
                analog_delay_ps[11*g+10:11*g] <= `ADLY_FIXED_PS + 11'(adly_code) * `ADLY_STEP_PS; // [R9]
            end
        end
    end

    // Per-output format decode; pins are driven from the group clock, never registered.
    for (genvar o = 0; o < 12; o++) begin : outp
        output_format_t fmt;
        assign fmt        = output_format_t'(fmt_r[o/4][`FMT_LSB+4*(o%4)+3:`FMT_LSB+4*(o%4)]); // [R6]
        assign out_clk[o] = grp_clk[o/2];

        always_comb begin
            clock_output_p[o] = 1'b0;
            clock_output_n[o] = 1'b0;
            unique case (fmt) // [R7]
                FMT_LVDS, FMT_PECL_700, FMT_PECL_1200, FMT_PECL_1600, FMT_PECL_2000, FMT_CMOS_NI: begin
                    clock_output_p[o] = out_clk[o];
                    clock_output_n[o] = !out_clk[o];
                end
                FMT_CMOS_IN: begin
                    clock_output_p[o] = !out_clk[o];
                    clock_output_n[o] = out_clk[o];
                end
                FMT_CMOS_NN: begin
                    clock_output_p[o] = out_clk[o];
                    clock_output_n[o] = out_clk[o];
                end
                FMT_CMOS_II: begin
                    clock_output_p[o] = !out_clk[o];
                    clock_output_n[o] = !out_clk[o];
                end
                FMT_CMOS_LN: clock_output_n[o] = out_clk[o];
                FMT_CMOS_LI: clock_output_n[o] = !out_clk[o];
                FMT_CMOS_NL: clock_output_p[o] = out_clk[o];
                FMT_CMOS_IL: clock_output_p[o] = !out_clk[o];
                default: begin
                    clock_output_p[o] = 1'b0;
                end
            endcase
        end

        // Registered class flags for the buffer bias; the reserved code powers the buffer down.
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                output_lvds[o]   <= 1'b0;
                output_lvpecl[o] <= 1'b0;
                output_lvcmos[o] <= 1'b0;
            end else begin
                output_lvds[o]   <= (fmt == FMT_LVDS); // [R7]
                output_lvpecl[o] <= (fmt >= FMT_PECL_700) && (fmt <= FMT_PECL_2000);
                output_lvcmos[o] <= (fmt >= FMT_CMOS_NI) && (fmt <= FMT_CMOS_LL);
            end
        end
    end

    // Reference buffered outputs.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ref_a_format <= 4'h0;
            ref_a_drive  <= 1'b0;
            ref_b_drive  <= 1'b0;
            ref_b_amp_mv <= 11'h000;
        end else begin
            ref_a_format <= refout_r[`REF_A_FMT_LSB+3:`REF_A_FMT_LSB]; // [R12]
            ref_a_drive  <= refout_r[`REF_A_EN_BIT] && (refout_r[`REF_A_FMT_LSB+3:`REF_A_FMT_LSB] != 4'h0)
                            && (refout_r[`REF_A_FMT_LSB+3:`REF_A_FMT_LSB] != 4'hF); // [R13]
            ref_b_drive  <= refout_r[`REF_B_EN_BIT];
            unique case (refout_r[`REF_B_AMP_LSB+1:`REF_B_AMP_LSB]) // [R11]
                2'h0: ref_b_amp_mv <= 11'h2BC;
                2'h1: ref_b_amp_mv <= 11'h4B0;
                2'h2: ref_b_amp_mv <= 11'h640;
                2'h3: ref_b_amp_mv <= 11'h7D0;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence fb_write_s;
        latch_pulse && wr_idx == `IDX_FB_DIV;
    endsequence
    chk_fb_write_sync: assert property (fb_write_s |=> sync_issued) else $error("no sync after feedback write"); // [R5]
    chk_ref_a_gate: assert property (##1 ref_a_drive |-> $past(refout_r[`REF_A_EN_BIT]) // [R13]
        && $past(refout_r[`REF_A_FMT_LSB+3:`REF_A_FMT_LSB]) != 4'h0) else $error("ref A drives while off");
    chk_delay_power: assert property (##1 delay_block_power[0] == ($past(group_r[0][`ADLY_SEL_X_BIT]) // [R10]
        | $past(group_r[0][`ADLY_SEL_Y_BIT]))) else $error("delay block power wrong");
    chk_delay_value: assert property (##1 analog_delay_ps[10:0] <= 11'h433) else $error("analog delay out of range"); // [R9]
    chk_pecl_amp: assert property (refout_r[31:30] == 2'h3 ##1 refout_r[31:30] == 2'h3 // [R11]
        |-> ref_b_amp_mv == 11'h7D0) else $error("ref B amplitude wrong");
    chk_power_down_pins: assert property (outp[0].fmt == FMT_POWER_DOWN // [R7]
        |-> !clock_output_p[0] && !clock_output_n[0]) else $error("powered down output toggles");
endmodule // clock_output_group_config
`default_nettype wire

// *** testbench/clk_sink_model.sv ***
// Downstream clocked device model that times the high and low phases of one clock pin.
`timescale 1ns/1ps
`default_nettype none
module clk_sink_model (
    input  wire logic        clk_in,
    output var  logic [31:0] hi_ns,
    output var  logic [31:0] lo_ns
);
    time t_rise = 0;
    time t_fall = 0;

    // A converter input only sees edges, so phase widths are all it can judge.
    always @(posedge clk_in) begin
        t_rise = $time;
        lo_ns <= 32'(t_rise - t_fall);
    end
    always @(negedge clk_in) begin
        t_fall = $time;
        hi_ns <= 32'(t_fall - t_rise);
    end
endmodule // clk_sink_model
`default_nettype wire

// *** testbench/clock_output_group_config_test.sv ***
// Self-checking bench for the clock output group configuration block.
`timescale 1ns/1ps
`default_nettype none
module clock_output_group_config_test;
    import clkgrp_pkg::*;
    logic        ref_clk   = 1'b0;
    logic        rstn      = 1'b0;
    logic        ser_clk   = 1'b0;
    logic        ser_data  = 1'b0;
    logic        ser_latch = 1'b0;
    logic        sync_req  = 1'b0;
    logic [11:0] clock_output_p, clock_output_n, output_lvds, output_lvpecl, output_lvcmos, analog_delay_on;
    logic [5:0]  group_extended, group_half_step, delay_block_power;
    logic [65:0] analog_delay_ps;
    logic [3:0]  ref_a_format;
    logic        ref_a_drive, ref_b_drive, sync_issued;
    logic [10:0] ref_b_amp_mv;
    logic [31:0] hi_ns, lo_ns;
    integer      seed = 32'hA780;
    int          n_errors = 0;
    int          check_count = 0;
    int          n_sync = 0;

    clock_output_group_config DUT (.ref_clk(ref_clk), .rstn(rstn), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_latch(ser_latch), .sync_req(sync_req), .clock_output_p(clock_output_p),
        .clock_output_n(clock_output_n), .output_lvds(output_lvds), .output_lvpecl(output_lvpecl),
        .output_lvcmos(output_lvcmos), .group_extended(group_extended), .group_half_step(group_half_step),
        .analog_delay_on(analog_delay_on), .delay_block_power(delay_block_power),
        .analog_delay_ps(analog_delay_ps), .ref_a_format(ref_a_format), .ref_a_drive(ref_a_drive),
        .ref_b_drive(ref_b_drive), .ref_b_amp_mv(ref_b_amp_mv), .sync_issued(sync_issued));
    clk_sink_model sink (.clk_in(clock_output_p[0]), .hi_ns(hi_ns), .lo_ns(lo_ns));

    // Clock, sync pulse counter and a watchdog so a hang still ends in a verdict.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (sync_issued === 1'b1) n_sync++;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        test_done();
    end

    task automatic test_done();
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Frames go out MSB first with the register index in the five low bits.
    task automatic wr(input logic [4:0] idx, input logic [31:0] val);
        logic [31:0] f;
        f = {val[31:5], idx};
        for (int i = 31; i >= 0; i--) begin
            cyc(1);
            ser_data = f[i];
            ser_clk = 1'b1;
            cyc(1);
            ser_clk = 1'b0;
        end
        cyc(1);
        ser_latch = 1'b1;
        cyc(1);
        ser_latch = 1'b0;
        cyc(3);
    endtask

    task automatic sync_now();
        cyc(1);
        sync_req = 1'b1;
        cyc(1);
        sync_req = 1'b0;
        cyc(4);
    endtask

    function automatic logic [2:0] fmt_class(input logic [3:0] c);
        return {c >= 4'h6 && c <= 4'hE, c >= 4'h2 && c <= 4'h5, c == 4'h1};
    endfunction

    // Pin pair {p, n} for a format code, given the level of the group clock.
    function automatic logic [1:0] pin_pair(input logic [3:0] c, input logic clk);
        case (c)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: return {clk, !clk};
            4'h7: return {!clk, clk};
            4'h8: return {clk, clk};
            4'h9: return {!clk, !clk};
            4'hA: return {1'b0, clk};
            4'hB: return {1'b0, !clk};
            4'hC: return {clk, 1'b0};
            4'hD: return {!clk, 1'b0};
            default: return 2'b00;
        endcase
    endfunction

    // Main sequence: divider timing first, then sync gating, then the decoded fields.
    initial begin
        int d, o, c, s, g, n0;
        logic [3:0] f;
        logic [2:0] cls;
        logic       p0;
        cyc(3);
        chk("ext_in_reset", 32'(group_extended), 32'h0);
        rstn = 1'b1;
        cyc(2);
        wr(5'h06, 32'h0001_0000);
        for (int k = 0; k < 6; k++) begin
            d = (k < 4) ? k + 1 : 5 + ($unsigned($random(seed)) % 5);
            wr(5'h00, 32'(d) << 5);
            sync_now();
            cyc(4 * d + 10);
            chk("high_ns", hi_ns, 32'(5 * d));
            chk("low_ns", lo_ns, 32'(5 * d));
        end
        wr(5'h00, 32'h0000_0320);
        sync_now();
        chk("ext_25", 32'(group_extended[0]), 32'h0);
        wr(5'h00, 32'h0000_0340);
        chk("ext_before_sync", 32'(group_extended[0]), 32'h0);
        sync_now();
        chk("ext_26", 32'(group_extended[0]), 32'h1);
        wr(5'h00, 32'h0000_0000);
        sync_now();
        chk("ext_div0", 32'(group_extended[0]), 32'h1);
        wr(5'h0B, 32'h0000_0020);
        wr(5'h00, 32'h0000_0040);
        n0 = n_sync;
        wr(5'h1E, 32'h0000_0600);
        chk("auto_sync", 32'(n_sync - n0), 32'h1);
        chk("ext_excluded", 32'(group_extended[0]), 32'h1);
        wr(5'h0B, 32'h0000_0000);
        wr(5'h1E, 32'h0000_0600);
        chk("ext_resynced", 32'(group_extended[0]), 32'h0);
        for (int k = 0; k < 15; k++) begin
            o = $unsigned($random(seed)) % 12;
            wr(5'(6 + o / 4), 32'(k) << (16 + 4 * (o % 4)));
            cls = {output_lvcmos[o], output_lvpecl[o], output_lvds[o]};
            chk("fmt_class", 32'(cls), 32'(fmt_class(4'(k))));
        end
        for (g = 0; g < 6; g++) begin
            c = $unsigned($random(seed)) % 32;
            s = $unsigned($random(seed)) % 8;
            // Divide two, since the half step may not be set on a group at divide one.
            wr(5'(g), {2'b00, s[1:0], 11'h000, s[2], 16'h0040});
            wr(5'(6 + g / 2), 32'(c) << ((g % 2) ? 11 : 5));
            chk("adly_ps", 32'(analog_delay_ps[11 * g +: 11]), 32'(500 + 25 * ((c > 23) ? 23 : c)));
            chk("adly_on", 32'(analog_delay_on[2 * g +: 2]), 32'(s[1:0]));
            chk("adly_pwr", 32'(delay_block_power[g]), 32'(|s[1:0]));
            chk("half_step", 32'(group_half_step[g]), 32'(s[2]));
        end
        for (int k = 0; k < 8; k++) begin
            f = (k == 0) ? 4'h0 : 4'($random(seed));
            s = $unsigned($random(seed)) % 4;
            wr(5'h0A, {2'(k % 4), 2'b00, f, s[1:0], 22'h0});
            chk("ref_b_amp", 32'(ref_b_amp_mv), 32'((k % 4 == 0) ? 700 : 800 + 400 * (k % 4)));
            chk("ref_a_fmt", 32'(ref_a_format), 32'(f));
            chk("ref_a_drive", 32'(ref_a_drive), 32'(s[0] && f != 4'h0 && f != 4'hF));
            chk("ref_b_drive", 32'(ref_b_drive), 32'(s[1]));
        end
        // Pin levels per format code; output 0 stays LVDS as the phase reference of group 0 at divide two.
        for (int k = 0; k < 16; k++) begin
            wr(5'h06, (32'(k) << 20) | 32'h0001_0000);
            for (int j = 0; j < 2; j++) begin
                p0 = clock_output_p[0];
                chk("ref_pins", 32'({clock_output_p[0], clock_output_n[0]}), 32'(pin_pair(4'h1, p0)));
                chk("fmt_pins", 32'({clock_output_p[1], clock_output_n[1]}), 32'(pin_pair(4'(k), p0)));
                cyc(1);
                chk("grp_toggle", 32'(clock_output_p[0]), 32'(!p0));
            end
        end
        test_done();
    end
endmodule // clock_output_group_config_test
`default_nettype wire
